// ### logic/cpurf_core.sv
// Purpose: Banked register file of a 16-bit CPU core with bus access
// Assumes: Datapath and bus share clk; ce low freezes all state
// Notes: Datapath write wins over a bus write to the same register
//
// Design decisions made here: the Avalon-MM interface to the registers and the address map.
module cpurf_core
  import cpurf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Datapath read port
  input wire logic [4:0] dp_rd_sel,
  output logic [31:0] dp_rd_data,
  // Datapath write port
  input wire logic dp_wr_en,
  input wire logic [4:0] dp_wr_sel,
  input wire logic [31:0] dp_wr_data,
  // Core state
  output logic [19:0] program_counter,
  output logic [19:0] vector_table_base,
  output logic [15:0] active_stack_pointer,
  output logic bank_select
);

  ////////////////////////////////////////////////////////////////////
  // Storage
  logic [15:0] data_reg [2][4];
  logic [15:0] addr_reg [2][2];
  logic [15:0] frame_base [2];
  logic [15:0] static_base;
  logic [15:0] user_stack_pointer;
  logic [15:0] interrupt_stack_pointer;
  logic [10:0] processor_flags;
  logic bank;
  logic stack_user;

  assign bank = processor_flags[FLAG_BANK_BIT];
  assign stack_user = processor_flags[FLAG_STACK_BIT];

  ////////////////////////////////////////////////////////////////////
  // Read decode shared by bus and datapath
  function automatic logic [31:0] read_operand(input logic [4:0] sel);
    logic [31:0] r;
    r = RST_BUS;
    case (sel)
      SEL_DATA_0, SEL_DATA_1, SEL_DATA_2, SEL_DATA_3:
        r = {16'h0000, data_reg[bank][sel[1:0]]};
      SEL_ADDR_0: r = {16'h0000, addr_reg[bank][0]};
      SEL_ADDR_1: r = {16'h0000, addr_reg[bank][1]};
      SEL_FRAME: r = {16'h0000, frame_base[bank]};
      SEL_STATIC: r = {16'h0000, static_base};
      SEL_USER_SP: r = {16'h0000, user_stack_pointer};
      SEL_INT_SP: r = {16'h0000, interrupt_stack_pointer};
      SEL_VECTOR: r = {12'h000, vector_table_base};
      SEL_PC: r = {12'h000, program_counter};
      SEL_FLAGS: r = {21'h000000, processor_flags};
      SEL_D0_LOW: r = {24'h000000, data_reg[bank][0][7:0]};
      SEL_D0_HIGH: r = {24'h000000, data_reg[bank][0][15:8]};
      SEL_D1_LOW: r = {24'h000000, data_reg[bank][1][7:0]};
      SEL_D1_HIGH: r = {24'h000000, data_reg[bank][1][15:8]};
      SEL_PAIR_LOW: r = {data_reg[bank][2], data_reg[bank][0]};
      SEL_PAIR_HIGH: r = {data_reg[bank][3], data_reg[bank][1]};
      SEL_ADDR_PAIR: r = {addr_reg[bank][1], addr_reg[bank][0]};
      SEL_ACTIVE_SP:
        r = {16'h0000, stack_user ? user_stack_pointer : interrupt_stack_pointer};
      default: r = RST_BUS;
    endcase
    return r;
  endfunction : read_operand

  ////////////////////////////////////////////////////////////////////
  // Write ports: index 0 bus, index 1 datapath (applied last)
  logic bus_wr_go;
  logic wr_en [2];
  logic [4:0] wr_sel [2];
  logic [31:0] wr_dat [2];

  assign bus_wr_go = ce && avs_write && !avs_waitrequest;
  assign wr_en[0] = bus_wr_go;
  assign wr_sel[0] = avs_address;
  assign wr_dat[0] = avs_writedata;
  assign wr_en[1] = ce && dp_wr_en;
  assign wr_sel[1] = dp_wr_sel;
  assign wr_dat[1] = dp_wr_data;

  ////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, then answer
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= RST_BUS;
    end
    else if (ce)
    begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest)
        avs_readdata <= read_operand(avs_address);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Datapath read port and state outputs
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dp_rd_data <= RST_BUS;
      active_stack_pointer <= RST_WORD;
      bank_select <= 1'b0;
    end
    else if (ce)
    begin
      dp_rd_data <= read_operand(dp_rd_sel);
      active_stack_pointer <= stack_user ? user_stack_pointer : interrupt_stack_pointer;
      bank_select <= bank;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Data registers, bytes and pairs
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int b = 0; b < 2; b++)
        for (int i = 0; i < 4; i++)
          data_reg[b][i] <= RST_WORD;
    end
    else
    begin
      for (int p = 0; p < 2; p++)
        if (wr_en[p])
        begin
          case (wr_sel[p])
            SEL_DATA_0, SEL_DATA_1, SEL_DATA_2, SEL_DATA_3:
              data_reg[bank][wr_sel[p][1:0]] <= wr_dat[p][15:0];
            SEL_D0_LOW: data_reg[bank][0][7:0] <= wr_dat[p][7:0];
            SEL_D0_HIGH: data_reg[bank][0][15:8] <= wr_dat[p][7:0];
            SEL_D1_LOW: data_reg[bank][1][7:0] <= wr_dat[p][7:0];
            SEL_D1_HIGH: data_reg[bank][1][15:8] <= wr_dat[p][7:0];
            SEL_PAIR_LOW:
            begin
              data_reg[bank][0] <= wr_dat[p][15:0];
              data_reg[bank][2] <= wr_dat[p][31:16];
            end
            SEL_PAIR_HIGH:
            begin
              data_reg[bank][1] <= wr_dat[p][15:0];
              data_reg[bank][3] <= wr_dat[p][31:16];
            end
            default: ;
          endcase
        end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Address registers and frame base
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int b = 0; b < 2; b++)
      begin
        addr_reg[b][0] <= RST_WORD;
        addr_reg[b][1] <= RST_WORD;
        frame_base[b] <= RST_WORD;
      end
    end
    else
    begin
      for (int p = 0; p < 2; p++)
        if (wr_en[p])
        begin
          case (wr_sel[p])
            SEL_ADDR_0: addr_reg[bank][0] <= wr_dat[p][15:0];
            SEL_ADDR_1: addr_reg[bank][1] <= wr_dat[p][15:0];
            // address pair, upper half in register 1
            SEL_ADDR_PAIR:
            begin
              addr_reg[bank][0] <= wr_dat[p][15:0];
              addr_reg[bank][1] <= wr_dat[p][31:16];
            end
            SEL_FRAME: frame_base[bank] <= wr_dat[p][15:0];
            default: ;
          endcase
        end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Unbanked registers and flags
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      static_base <= RST_WORD;
      user_stack_pointer <= RST_WORD;
      interrupt_stack_pointer <= RST_WORD;
      vector_table_base <= RST_WIDE;
      program_counter <= RST_WIDE;
      processor_flags <= RST_FLAGS;
    end
    else
    begin
      for (int p = 0; p < 2; p++)
        if (wr_en[p])
        begin
          case (wr_sel[p])
            SEL_STATIC: static_base <= wr_dat[p][15:0];
            SEL_USER_SP: user_stack_pointer <= wr_dat[p][15:0];
            SEL_INT_SP: interrupt_stack_pointer <= wr_dat[p][15:0];
            SEL_ACTIVE_SP:
              if (stack_user)
                user_stack_pointer <= wr_dat[p][15:0];
              else
                interrupt_stack_pointer <= wr_dat[p][15:0];
            SEL_VECTOR: vector_table_base <= wr_dat[p][19:0];
            SEL_PC: program_counter <= wr_dat[p][19:0];
            // bank and stack select live here
            SEL_FLAGS: processor_flags <= wr_dat[p][10:0];
            default: ;
          endcase
        end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence dp_write(logic [4:0] s);
    ce && dp_wr_en && dp_wr_sel == s;
  endsequence

  sequence bus_request;
    ce && (avs_read || avs_write) && avs_waitrequest;
  endsequence

  byte_high_keep_a: assert property (
    dp_write(SEL_D0_LOW) ##0 !bus_wr_go |=>
      data_reg[$past(bank)][0][15:8] == $past(data_reg[bank][0][15:8]) &&
      data_reg[$past(bank)][0][7:0] == $past(dp_wr_data[7:0]))
    else $error("low byte write disturbed high byte");

  byte_low_keep_a: assert property (
    dp_write(SEL_D1_HIGH) ##0 !bus_wr_go |=>
      data_reg[$past(bank)][1][7:0] == $past(data_reg[bank][1][7:0]) &&
      data_reg[$past(bank)][1][15:8] == $past(dp_wr_data[7:0]))
    else $error("high byte write disturbed low byte");

  data_pair_a: assert property (
    dp_write(SEL_PAIR_LOW) ##0 !bus_wr_go |=>
      data_reg[$past(bank)][2] == $past(dp_wr_data[31:16]) &&
      data_reg[$past(bank)][0] == $past(dp_wr_data[15:0]))
    else $error("data pair halves misplaced");

  addr_pair_a: assert property (
    dp_write(SEL_ADDR_PAIR) ##0 !bus_wr_go |=>
      addr_reg[$past(bank)][1] == $past(dp_wr_data[31:16]) &&
      addr_reg[$past(bank)][0] == $past(dp_wr_data[15:0]))
    else $error("address pair halves misplaced");

  bank_read_a: assert property (
    ce && dp_rd_sel == SEL_FRAME |=> dp_rd_data ==
      {16'h0000, bank_select ? $past(frame_base[1]) : $past(frame_base[0])})
    else $error("operand read from wrong bank");

  stack_select_a: assert property (
    ce ##1 ce |-> active_stack_pointer ==
      ($past(stack_user) ? $past(user_stack_pointer) : $past(interrupt_stack_pointer)))
    else $error("active stack pointer not per select flag");

  pc_load_a: assert property (
    dp_write(SEL_PC) |=> program_counter == $past(dp_wr_data[19:0]))
    else $error("program counter load lost");

  vector_load_a: assert property (
    dp_write(SEL_VECTOR) |=> vector_table_base == $past(dp_wr_data[19:0]))
    else $error("vector table base load lost");

  static_hold_a: assert property (
    ce && !(wr_en[0] && wr_sel[0] == SEL_STATIC) &&
      !(wr_en[1] && wr_sel[1] == SEL_STATIC) |=> $stable(static_base))
    else $error("static base changed without write");

  bus_write_land_a: assert property (
    bus_wr_go && avs_address == SEL_STATIC &&
      !(wr_en[1] && wr_sel[1] == SEL_STATIC) |=>
      static_base == $past(avs_writedata[15:0]))
    else $error("bus write to static base lost");

  wait_one_a: assert property (
    bus_request ##1 ce |-> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not exactly one cycle");

  ce_freeze_a: assert property (
    !ce |=> $stable(program_counter) && $stable(vector_table_base) &&
      $stable(avs_waitrequest) && $stable(dp_rd_data) && $stable(processor_flags))
    else $error("state moved while clock enable low");

  bus_answer_a: assert property (
    bus_request ##0 avs_read && avs_address == SEL_DATA_2 && !dp_wr_en |=>
      !avs_waitrequest && avs_readdata[15:0] == $past(data_reg[bank][2]))
    else $error("bus read answer wrong or late");

endmodule : cpurf_core

// ### logic/cpurf_pkg.sv
// Purpose: Shared constants of the CPU core register file
// Assumes: One core clock, word-indexed register bus
// Notes: Operand select codes double as bus word indexes
package cpurf_pkg;

  // Widths
  localparam int CPURF_WORD_W = 16;
  localparam int CPURF_WIDE_W = 20;
  localparam int CPURF_FLAG_W = 11;
  localparam int CPURF_SEL_W = 5;

  // Operand select codes, also bus word indexes (byte address = 4 * index)
  localparam logic [4:0] SEL_DATA_0 = 5'h00;
  localparam logic [4:0] SEL_DATA_1 = 5'h01;
  localparam logic [4:0] SEL_DATA_2 = 5'h02;
  localparam logic [4:0] SEL_DATA_3 = 5'h03;
  localparam logic [4:0] SEL_ADDR_0 = 5'h04;
  localparam logic [4:0] SEL_ADDR_1 = 5'h05;
  localparam logic [4:0] SEL_FRAME = 5'h06;
  localparam logic [4:0] SEL_STATIC = 5'h07;
  localparam logic [4:0] SEL_USER_SP = 5'h08;
  localparam logic [4:0] SEL_INT_SP = 5'h09;
  localparam logic [4:0] SEL_VECTOR = 5'h0a;
  localparam logic [4:0] SEL_PC = 5'h0b;
  localparam logic [4:0] SEL_FLAGS = 5'h0c;
  localparam logic [4:0] SEL_D0_LOW = 5'h0d;
  localparam logic [4:0] SEL_D0_HIGH = 5'h0e;
  localparam logic [4:0] SEL_D1_LOW = 5'h0f;
  localparam logic [4:0] SEL_D1_HIGH = 5'h10;
  localparam logic [4:0] SEL_PAIR_LOW = 5'h11;
  localparam logic [4:0] SEL_PAIR_HIGH = 5'h12;
  localparam logic [4:0] SEL_ADDR_PAIR = 5'h13;
  localparam logic [4:0] SEL_ACTIVE_SP = 5'h14;

  // Flag bit positions
  localparam int FLAG_BANK_BIT = 4;
  localparam int FLAG_STACK_BIT = 7;

  // Values after reset
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [19:0] RST_WIDE = 20'h00000;
  localparam logic [10:0] RST_FLAGS = 11'h000;
  localparam logic [31:0] RST_BUS = 32'h00000000;

endpackage : cpurf_pkg

// ### sim/cpurf_dp_model.sv
// Purpose: Datapath side model driving the register file operand ports
// Assumes: One datapath access at a time, launched after a rising edge
// Notes: Read results are taken at the edge after they are loaded
module cpurf_dp_model
  import cpurf_pkg::*;
(
  // Clock
  input wire logic clk,
  // Datapath ports
  output logic [4:0] dp_rd_sel,
  input wire logic [31:0] dp_rd_data,
  output logic dp_wr_en,
  output logic [4:0] dp_wr_sel,
  output logic [31:0] dp_wr_data
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    dp_rd_sel = SEL_DATA_0;
    dp_wr_en = 1'b0;
    dp_wr_sel = SEL_DATA_0;
    dp_wr_data = 32'h0;
  end

  // One-cycle write strobe, data scrambled once released
  task automatic dp_write(input logic [4:0] sel, input logic [31:0] data);
    @(posedge clk);
    dp_wr_en <= 1'b1;
    dp_wr_sel <= sel;
    dp_wr_data <= data;
    @(posedge clk);
    dp_wr_en <= 1'b0;
    dp_wr_data <= ~data;
  endtask : dp_write

  task automatic dp_read(input logic [4:0] sel, output logic [31:0] data);
    @(posedge clk);
    dp_rd_sel <= sel;
    @(posedge clk);
    @(posedge clk);
    data = dp_rd_data;
  endtask : dp_read

endmodule : cpurf_dp_model

// ### sim/testbench.sv
// Purpose: Self-checking bench of the register file over bus and datapath
// Assumes: Avalon master waits for waitrequest low, ce driven by the bench
// Notes: Expected values are built from the select codes and widths
module testbench
  import cpurf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  logic [4:0] avs_address = 5'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [4:0] dp_rd_sel;
  logic [31:0] dp_rd_data;
  logic dp_wr_en;
  logic [4:0] dp_wr_sel;
  logic [31:0] dp_wr_data;
  logic [19:0] program_counter;
  logic [19:0] vector_table_base;
  logic [15:0] active_stack_pointer;
  logic bank_select;
  logic [31:0] rd;
  logic [31:0] exp_v;
  int fails = 0;
  int n_tests = 0;

  always #25 clk = ~clk;

  cpurf_core u_cpurf_core (.clk(clk), .reset_n(reset_n), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .dp_rd_sel(dp_rd_sel), .dp_rd_data(dp_rd_data),
    .dp_wr_en(dp_wr_en), .dp_wr_sel(dp_wr_sel), .dp_wr_data(dp_wr_data),
    .program_counter(program_counter), .vector_table_base(vector_table_base),
    .active_stack_pointer(active_stack_pointer), .bank_select(bank_select));

  cpurf_dp_model u_cpurf_dp_model (.clk(clk), .dp_rd_sel(dp_rd_sel),
    .dp_rd_data(dp_rd_data), .dp_wr_en(dp_wr_en), .dp_wr_sel(dp_wr_sel),
    .dp_wr_data(dp_wr_data));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus_wait;
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0);
  endtask : bus_wait

  task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    bus_wait();
    avs_write <= 1'b0;
    avs_writedata <= ~d;
  endtask : bus_wr

  task automatic bus_rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read <= 1'b1;
    bus_wait();
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask : bus_rd

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    test_done();
  end

  initial
  begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    bus_rd(SEL_PC, rd);
    chk(rd, 32'h0);
    $display("test reset done");
    // Every plain register below the flags keeps its own width
    for (int i = 0; i < 12; i++)
      bus_wr(5'(i), 32'h000a1234 + 32'(i) * 32'h1111);
    for (int i = 0; i < 12; i++)
    begin
      exp_v = (32'h000a1234 + 32'(i) * 32'h1111) & (i < 10 ? 32'hffff : 32'hfffff);
      bus_rd(5'(i), rd);
      chk(rd, exp_v);
    end
    chk({12'h0, program_counter}, 32'h000acdef);
    chk({12'h0, vector_table_base}, 32'h000abcde);
    $display("test widths done");
    bus_wr(SEL_FLAGS, 32'h80);
    bus_rd(SEL_ACTIVE_SP, rd);
    chk(rd, 32'h9abc);
    chk({16'h0, active_stack_pointer}, 32'h9abc);
    bus_wr(SEL_FLAGS, 32'h00);
    u_cpurf_dp_model.dp_read(SEL_ACTIVE_SP, rd);
    chk(rd, 32'habcd);
    $display("test stack done");
    bus_wr(SEL_FLAGS, 32'h10);
    bus_rd(SEL_DATA_0, rd);
    chk(rd, 32'h0);
    chk({31'h0, bank_select}, 32'h1);
    bus_wr(SEL_DATA_0, 32'h5555);
    bus_wr(SEL_FRAME, 32'h0f0f);
    u_cpurf_dp_model.dp_read(SEL_FRAME, rd);
    chk(rd, 32'h0f0f);
    bus_wr(SEL_FLAGS, 32'h00);
    bus_rd(SEL_DATA_0, rd);
    chk(rd, 32'h1234);
    chk({31'h0, bank_select}, 32'h0);
    u_cpurf_dp_model.dp_read(SEL_FRAME, rd);
    chk(rd, 32'h789a);
    $display("test bank done");
    bus_wr(SEL_D0_HIGH, 32'h00ab);
    u_cpurf_dp_model.dp_write(SEL_D0_LOW, 32'h00cd);
    bus_rd(SEL_DATA_0, rd);
    chk(rd, 32'habcd);
    bus_wr(SEL_D1_LOW, 32'h0077);
    u_cpurf_dp_model.dp_read(SEL_DATA_1, rd);
    chk(rd, 32'h2377);
    u_cpurf_dp_model.dp_write(SEL_D1_HIGH, 32'h0099);
    bus_rd(SEL_DATA_1, rd);
    chk(rd, 32'h9977);
    bus_rd(SEL_D0_HIGH, rd);
    chk(rd, 32'h00ab);
    $display("test bytes done");
    u_cpurf_dp_model.dp_write(SEL_PAIR_LOW, 32'hdeadbeef);
    bus_rd(SEL_DATA_2, rd);
    chk(rd, 32'hdead);
    bus_rd(SEL_DATA_0, rd);
    chk(rd, 32'hbeef);
    bus_wr(SEL_PAIR_HIGH, 32'hcafe0042);
    u_cpurf_dp_model.dp_read(SEL_PAIR_HIGH, rd);
    chk(rd, 32'hcafe0042);
    bus_wr(SEL_ADDR_PAIR, 32'h01234567);
    u_cpurf_dp_model.dp_read(SEL_ADDR_1, rd);
    chk(rd, 32'h0123);
    u_cpurf_dp_model.dp_write(SEL_ADDR_PAIR, 32'h89abcdef);
    bus_rd(SEL_ADDR_PAIR, rd);
    chk(rd, 32'h89abcdef);
    bus_rd(SEL_ADDR_0, rd);
    chk(rd, 32'hcdef);
    $display("test pairs done");
    bus_wr(5'h15, 32'hffffffff);
    bus_rd(5'h15, rd);
    chk(rd, 32'h0);
    $display("test unmapped done");
    // Clock enable low must swallow a datapath write
    @(posedge clk);
    ce <= 1'b0;
    u_cpurf_dp_model.dp_write(SEL_PC, 32'h00054321);
    ce <= 1'b1;
    chk({12'h0, program_counter}, 32'h000acdef);
    u_cpurf_dp_model.dp_write(SEL_PC, 32'h00012345);
    u_cpurf_dp_model.dp_write(SEL_VECTOR, 32'h123f00d5);
    chk({12'h0, program_counter}, 32'h00012345);
    @(posedge clk);
    chk({12'h0, vector_table_base}, 32'h000f00d5);
    $display("test enable done");
    test_done();
  end

endmodule : testbench
